// [verilog/cmi_pkg.sv]
// Purpose: shared constants and types of the clock monitor interrupt block
// Assumes: one 40 MHz system clock, synchronous active-low reset
// Notes:   register indices select words on the internal register port

package cmi_pkg;

    // ****************************************
    // register port
    // ****************************************
    localparam int unsigned CMI_IDX_W = 2;
    localparam int unsigned CMI_DATA_W = 16;
    localparam logic [1:0] CMI_IDX_ENABLE = 2'h0;
    localparam logic [1:0] CMI_IDX_STATUS = 2'h1;
    localparam logic [1:0] CMI_IDX_LOSS_EVT = 2'h2;

    // ****************************************
    // field positions, shared by enable and status words
    // ****************************************
    localparam int unsigned CMI_BIT_DEVICE = 15;
    localparam int unsigned CMI_BIT_LOAD_FAIL = 11;
    localparam int unsigned CMI_BIT_LOAD_ERR = 10;
    localparam int unsigned CMI_BIT_MANUAL_RDY = 9;
    localparam int unsigned CMI_BIT_CPL_ACT = 8;
    localparam int unsigned CMI_BIT_TRUE_ACT = 7;
    localparam int unsigned CMI_BIT_XTAL_LOSS = 6;
    localparam int unsigned CMI_BIT_CPL_LOSS = 5;
    localparam int unsigned CMI_BIT_TRUE_LOSS = 4;
    localparam int unsigned CMI_NUM_LOSS = 3;

    // ****************************************
    // reset values and masks
    // ****************************************
    localparam logic [15:0] CMI_ENABLE_RST = 16'h0000;
    localparam logic [15:0] CMI_ENABLE_WMASK = 16'h8FF0;
    localparam logic [15:0] CMI_SOURCE_MASK = 16'h0FF0;
    localparam logic [2:0] CMI_LOSS_EVT_RST = 3'h7;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] idx;
        logic [15:0] wdata;
    } cmi_req_t;

    typedef struct packed {
        logic rd_valid;
        logic [15:0] rdata;
    } cmi_rsp_t;

    // loss monitors: bit 0 true input, 1 complement, 2 crystal
    typedef struct packed {
        logic [2:0] cond;
        logic [2:0] mon_rst;
    } cmi_loss_in_t;

endpackage

// [verilog/cmi_loss_events.sv]
// Purpose: sticky loss-of-signal event bits, write-one-to-clear
// Assumes: condition and monitor reset are synchronous to clk
// Notes:   a live condition always beats a clear from software

`timescale 1ns/1ps

module cmi_loss_events
    import cmi_pkg::*;
#(
    parameter int unsigned NUM = CMI_NUM_LOSS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [NUM-1:0] cond,
    input wire logic [NUM-1:0] mon_rst,
    input wire logic [NUM-1:0] clr,
    output logic [NUM-1:0] evt
);

    logic [NUM-1:0] evt_ff;
    logic [NUM-1:0] nxt_evt;

    // ****************************************
    // per-monitor event bit
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NUM; g++) begin : g_evt
            // set wins over clear, so no loss is ever dropped
            always_comb begin
                nxt_evt[g] = evt_ff[g];
                if (clr[g]) begin
                    nxt_evt[g] = 1'b0;
                end
                if (cond[g] || mon_rst[g]) begin
                    nxt_evt[g] = 1'b1; // see R10
                end
            end
        end
    endgenerate

    // register only; reset leaves every bit set as monitors start
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            evt_ff <= NUM'(CMI_LOSS_EVT_RST); // see R10
        end else begin
            evt_ff <= nxt_evt;
        end
    end

    assign evt = evt_ff;

endmodule

// [verilog/cmi_status_merge.sv]
// Purpose: builds the interrupt status word from the source event bits
// Assumes: all inputs are levels held by their owners
// Notes:   purely combinational; the top registers the result

`timescale 1ns/1ps

module cmi_status_merge
    import cmi_pkg::*;
#(
    parameter int unsigned FAIL_W = 4,
    parameter int unsigned CRC_W = 4
) (
    input wire logic [FAIL_W-1:0] load_fail_evt,
    input wire logic [CRC_W-1:0] crc_err_evt,
    input wire logic manual_rdy_evt,
    input wire logic [1:0] act_evt,
    input wire logic [2:0] loss_evt,
    input wire logic [15:0] enable,
    output logic [15:0] status
);

    logic [15:0] src;

    // ****************************************
    // source bits and overall flag
    // ****************************************
    always_comb begin
        src = 16'h0000;
        src[CMI_BIT_LOAD_FAIL] = |load_fail_evt; // see R5
        src[CMI_BIT_LOAD_ERR] = |crc_err_evt; // see R6
        src[CMI_BIT_MANUAL_RDY] = manual_rdy_evt; // see R7
        src[CMI_BIT_CPL_ACT] = act_evt[1]; // see R8
        src[CMI_BIT_TRUE_ACT] = act_evt[0]; // see R8
        src[CMI_BIT_XTAL_LOSS] = loss_evt[2]; // see R9
        src[CMI_BIT_CPL_LOSS] = loss_evt[1]; // see R9
        src[CMI_BIT_TRUE_LOSS] = loss_evt[0]; // see R9
        status = src;
        // each source gated by its own enable bit
        status[CMI_BIT_DEVICE] =
            |(src & enable & CMI_SOURCE_MASK); // see R2 see R4
    end

endmodule

// [verilog/cmi_aggregator.sv]
// Purpose: interrupt aggregator of the clock monitors and the OTP loader
// Assumes: register port strobes and source levels are synchronous to clk
// Notes:   interrupt, and lock pin when it selects the interrupt, follow the sources one clock later
//
// Contract
// R1: interrupt asserts only when master enable bit 15 and overall status set.
// R2: overall status bit 15 is OR of every source bit ANDed with enable.
// R3: gated interrupt drives lock pin when pin select picks the interrupt.
// R4: enable bits 11 to 4 include their source when 1, exclude when 0.
// R5: status bit 11 is OR of all loader failure event bits.
// R6: status bit 10 is OR of all OTP checksum error event bits.
// R7: status bit 9 follows the manual request ready event, no storage.
// R8: bit 8 mirrors complement input activity, bit 7 true input activity.
// R9: bits 6, 5, 4 mirror crystal, complement, true input loss events.
// R10: loss event clears on write one, held during loss, set at monitor reset.
// R11: interrupt is a level, dropping once enabled sources clear or disable.

`timescale 1ns/1ps

module cmi_aggregator
    import cmi_pkg::*;
#(
    parameter int unsigned FAIL_W = 4,
    parameter int unsigned CRC_W = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire cmi_req_t req,
    output cmi_rsp_t rsp,
    input wire logic [FAIL_W-1:0] load_fail_evt,
    input wire logic [CRC_W-1:0] crc_err_evt,
    input wire logic manual_rdy_evt,
    input wire logic true_input_activity_evt,
    input wire logic complement_activity_evt,
    input wire cmi_loss_in_t loss_in,
    input wire logic lock_sel_interrupt,
    input wire logic lock_other_level,
    output logic device_irq,
    output logic lock_pin
);

    // ****************************************
    // declarations
    // ****************************************
    logic [15:0] enable_ff;
    logic [15:0] nxt_enable;
    logic [15:0] status;
    logic [2:0] loss_evt;
    logic [2:0] loss_clr;
    logic irq_ff;
    logic nxt_irq;
    logic lock_pin_ff;
    logic nxt_lock_pin;
    logic rd_valid_ff;
    logic nxt_rd_valid;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic hit_enable;
    logic hit_status;
    logic hit_loss;

    // ****************************************
    // address decode
    // ****************************************
    // unmapped indices read zero and ignore writes
    always_comb begin
        hit_enable = (req.idx == CMI_IDX_ENABLE);
        hit_status = (req.idx == CMI_IDX_STATUS);
        hit_loss = (req.idx == CMI_IDX_LOSS_EVT);
    end

    // ****************************************
    // loss event bits
    // ****************************************
    // write one clears; the keeper lets a live loss win over it
    always_comb begin
        loss_clr = 3'h0;
        if (req.wr && hit_loss) begin
            loss_clr = req.wdata[2:0]; // see R10
        end
    end

    cmi_loss_events #(
        .NUM(CMI_NUM_LOSS)
    ) i_cmi_loss_events (
        .clk(clk),
        .rst_b(rst_b),
        .cond(loss_in.cond),
        .mon_rst(loss_in.mon_rst),
        .clr(loss_clr),
        .evt(loss_evt)
    );

    // ****************************************
    // status word
    // ****************************************
    cmi_status_merge #(
        .FAIL_W(FAIL_W),
        .CRC_W(CRC_W)
    ) i_cmi_status_merge (
        .load_fail_evt(load_fail_evt),
        .crc_err_evt(crc_err_evt),
        .manual_rdy_evt(manual_rdy_evt),
        .act_evt({complement_activity_evt, true_input_activity_evt}),
        .loss_evt(loss_evt),
        .enable(enable_ff),
        .status(status)
    );

    // ****************************************
    // enable register
    // ****************************************
    // reserved bits are masked so they always read zero
    always_comb begin
        nxt_enable = enable_ff;
        if (req.wr && hit_enable) begin
            nxt_enable = req.wdata & CMI_ENABLE_WMASK; // see R4
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            enable_ff <= CMI_ENABLE_RST;
        end else begin
            enable_ff <= nxt_enable;
        end
    end

    // ****************************************
    // interrupt and lock pin
    // ****************************************
    // level output, no latch: it drops one clock after the sources do
    always_comb begin
        nxt_irq = enable_ff[CMI_BIT_DEVICE]
            & status[CMI_BIT_DEVICE]; // see R1 see R11
        nxt_lock_pin = lock_other_level;
        if (lock_sel_interrupt) begin
            nxt_lock_pin = nxt_irq; // see R3
        end
    end

    // both outputs come from flops to keep the pin glitch free
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
            lock_pin_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
            lock_pin_ff <= nxt_lock_pin;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // read data is captured in the strobe cycle and shown one clock later
    always_comb begin
        nxt_rd_valid = req.rd;
        nxt_rdata = 16'h0000;
        if (req.rd) begin
            case (req.idx)
                CMI_IDX_ENABLE: begin
                    nxt_rdata = enable_ff;
                end
                CMI_IDX_STATUS: begin
                    nxt_rdata = status; // see R2
                end
                CMI_IDX_LOSS_EVT: begin
                    nxt_rdata = {13'h0000, loss_evt};
                end
                default: begin
                    nxt_rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_valid_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            rd_valid_ff <= nxt_rd_valid;
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rsp.rd_valid = rd_valid_ff;
    assign rsp.rdata = rdata_ff;
    assign device_irq = irq_ff;
    assign lock_pin = lock_pin_ff;

endmodule

// [bench/cmi_aggregator_checker.sv]
// Purpose: port assertions of the interrupt aggregator
// Assumes: shadow words mirror the enable and loss event registers
// Notes: status read timing is judged by the bench only
`timescale 1ns/1ps
module cmi_aggregator_checker
    import cmi_pkg::*;
#(
    parameter int unsigned FAIL_W = 4,
    parameter int unsigned CRC_W = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire cmi_req_t req,
    input wire cmi_rsp_t rsp,
    input wire logic [FAIL_W-1:0] load_fail_evt,
    input wire logic [CRC_W-1:0] crc_err_evt,
    input wire logic manual_rdy_evt,
    input wire logic true_input_activity_evt,
    input wire logic complement_activity_evt,
    input wire cmi_loss_in_t loss_in,
    input wire logic lock_sel_interrupt,
    input wire logic lock_other_level,
    input wire logic device_irq,
    input wire logic lock_pin
);
    // ****
    // shadows
    // ****
    logic [15:0] en_ff, nxt_en;
    logic [2:0] evt_ff, nxt_evt, hold;
    logic [7:0] src;
    logic irq_calc;
    // a live loss or monitor reset beats a software clear
    always_comb begin
        hold = loss_in.cond | loss_in.mon_rst;
        nxt_en = en_ff;
        nxt_evt = hold | evt_ff;
        if (req.wr && req.idx == CMI_IDX_ENABLE) begin
            nxt_en = req.wdata & CMI_ENABLE_WMASK;
        end
        if (req.wr && req.idx == CMI_IDX_LOSS_EVT) begin
            nxt_evt = hold | (evt_ff & ~req.wdata[2:0]);
        end
        src = {|load_fail_evt, |crc_err_evt, manual_rdy_evt,
            complement_activity_evt, true_input_activity_evt, evt_ff};
        irq_calc = en_ff[15] & |(src & en_ff[11:4]);
    end
    // registered like the design so both see the same edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            en_ff <= CMI_ENABLE_RST;
            evt_ff <= CMI_LOSS_EVT_RST;
        end else begin
            en_ff <= nxt_en;
            evt_ff <= nxt_evt;
        end
    end
    // ****
    // assertions
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_rd(logic [1:0] i);
        req.rd && req.idx == i;
    endsequence
    a_irq_level: assert property ($past(rst_b) |->
        device_irq == $past(irq_calc)) else $error("irq level wrong");
    a_master_gate: assert property (!$past(en_ff[15]) |->
        !device_irq) else $error("irq without master enable");
    a_lock_irq: assert property ($past(lock_sel_interrupt) |->
        lock_pin == device_irq) else $error("lock pin not irq");
    a_lock_other: assert property ($past(rst_b) &&
        !$past(lock_sel_interrupt) |-> lock_pin == $past(lock_other_level))
        else $error("lock pin level wrong");
    a_rd_pulse: assert property (req.rd |=> rsp.rd_valid)
        else $error("read not answered");
    a_rd_idle: assert property (!rsp.rd_valid |->
        rsp.rdata == 16'h0000) else $error("idle read data");
    a_en_read: assert property (s_rd(CMI_IDX_ENABLE) |=>
        rsp.rdata == $past(en_ff)) else $error("enable read wrong");
    a_loss_read: assert property (s_rd(CMI_IDX_LOSS_EVT) |=>
        rsp.rdata == {13'h0000, $past(evt_ff)}) else $error("loss read");
    a_spare_read: assert property (s_rd(2'h3) |=>
        rsp.rdata == 16'h0000) else $error("unmapped read");
endmodule
bind cmi_aggregator cmi_aggregator_checker #(.FAIL_W(FAIL_W), .CRC_W(CRC_W))
    i_cmi_aggregator_checker (.clk(clk), .rst_b(rst_b), .req(req),
    .rsp(rsp), .load_fail_evt(load_fail_evt), .crc_err_evt(crc_err_evt),
    .manual_rdy_evt(manual_rdy_evt),
    .true_input_activity_evt(true_input_activity_evt),
    .complement_activity_evt(complement_activity_evt), .loss_in(loss_in),
    .lock_sel_interrupt(lock_sel_interrupt),
    .lock_other_level(lock_other_level), .device_irq(device_irq),
    .lock_pin(lock_pin));

// [bench/cmi_aggregator_tb_top.sv]
// Purpose: directed bench of the interrupt aggregator
// Assumes: inputs change on the falling edge
// Notes: loss events must be cleared before source tests
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module cmi_aggregator_tb_top
    import cmi_pkg::*;
;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    cmi_req_t req = 20'h00000;
    cmi_rsp_t rsp;
    logic [3:0] fail = 4'h0, crc = 4'h0;
    logic man = 1'h0, tact = 1'h0, cact = 1'h0, sel = 1'h1, oth = 1'h0;
    cmi_loss_in_t loss = 6'h00;
    logic irq, lock;
    int n_errors = 0, check_count = 0;
    // 40 MHz system clock
    always #12.5 clk = ~clk;
    cmi_aggregator i_cmi_aggregator (.clk(clk), .rst_b(rst_b), .req(req),
        .rsp(rsp), .load_fail_evt(fail), .crc_err_evt(crc),
        .manual_rdy_evt(man), .true_input_activity_evt(tact),
        .complement_activity_evt(cact), .loss_in(loss),
        .lock_sel_interrupt(sel), .lock_other_level(oth),
        .device_irq(irq), .lock_pin(lock));
    // ****
    // port tasks
    // ****
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [1:0] i, input logic [15:0] d);
        @(negedge clk);
        req = {1'h1, 1'h0, i, d};
        @(negedge clk);
        req = 20'h00000;
    endtask
    // answer stands one cycle, so it is judged in that cycle
    task automatic rd(input logic [1:0] i, input logic [15:0] e);
        @(negedge clk);
        req = {1'h0, 1'h1, i, 16'h0000};
        @(negedge clk);
        req = 20'h00000;
        `CHK(rsp.rd_valid, 1'h1)
        `CHK(rsp.rdata, e)
    endtask
    task automatic put(input int b, input logic v);
        case (b)
            4, 5, 6: loss.cond[b-4] = v;
            7: tact = v;
            8: cact = v;
            9: man = v;
            10: crc[3] = v;
            default: fail[2] = v;
        endcase
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        rd(CMI_IDX_ENABLE, 16'h0000);
        rd(CMI_IDX_LOSS_EVT, 16'h0007);
        rd(CMI_IDX_STATUS, 16'h0070);
        rd(2'h3, 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_loss();
        loss.cond = 3'h2;
        wr(CMI_IDX_LOSS_EVT, 16'h0007);
        rd(CMI_IDX_LOSS_EVT, 16'h0002);
        loss = 6'h20;
        wr(CMI_IDX_LOSS_EVT, 16'h0007);
        rd(CMI_IDX_LOSS_EVT, 16'h0004);
        loss = 6'h00;
        wr(CMI_IDX_LOSS_EVT, 16'h0004);
        rd(CMI_IDX_LOSS_EVT, 16'h0000);
        // a monitor held in reset keeps its event set against a clear
        loss = 6'h01;
        wr(CMI_IDX_LOSS_EVT, 16'h0007);
        rd(CMI_IDX_LOSS_EVT, 16'h0001);
        loss = 6'h00;
        wr(CMI_IDX_LOSS_EVT, 16'h0001);
        rd(CMI_IDX_LOSS_EVT, 16'h0000);
        $display("loss test done");
    endtask
    task automatic t_enable();
        wr(CMI_IDX_ENABLE, 16'hFFFF);
        rd(CMI_IDX_ENABLE, 16'h8FF0);
        wr(CMI_IDX_STATUS, 16'hFFFF);
        wr(2'h3, 16'hFFFF);
        rd(CMI_IDX_STATUS, 16'h0000);
        rd(2'h3, 16'h0000);
        $display("enable test done");
    endtask
    // each source alone: on, excluded, master off, then dropped
    task automatic t_src();
        for (int b = 4; b < 12; b++) begin
            wr(CMI_IDX_ENABLE, 16'h8000 | (16'h0001 << b));
            put(b, 1'h1);
            tick(3);
            `CHK(irq, 1'h1)
            `CHK(lock, 1'h1)
            rd(CMI_IDX_STATUS, 16'h8000 | 16'h0001 << b);
            wr(CMI_IDX_ENABLE, 16'h8FF0 ^ (16'h0001 << b));
            tick(2);
            `CHK(irq, 1'h0)
            wr(CMI_IDX_ENABLE, 16'h0001 << b);
            tick(2);
            `CHK(irq, 1'h0)
            wr(CMI_IDX_ENABLE, 16'h8000 | (16'h0001 << b));
            put(b, 1'h0);
            wr(CMI_IDX_LOSS_EVT, 16'h0007);
            tick(3);
            `CHK(irq, 1'h0)
            `CHK(lock, 1'h0)
        end
        $display("source test done");
    endtask
    // interrupt held high so the other function must hide it from the pin
    task automatic t_lock();
        fail = 4'h1;
        sel = 1'h0;
        oth = 1'h1;
        tick(2);
        `CHK(lock, 1'h1)
        `CHK(irq, 1'h1)
        oth = 1'h0;
        tick(2);
        `CHK(lock, 1'h0)
        fail = 4'h0;
        sel = 1'h1;
        tick(2);
        `CHK(lock, 1'h0)
        `CHK(irq, 1'h0)
        $display("lock test done");
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // main sequence after four reset cycles
    initial begin
        tick(4);
        rst_b = 1'h1;
        t_reset();
        t_loss();
        t_enable();
        t_src();
        t_lock();
        end_of_test();
    end
    // watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
endmodule
